// ### verilog/pda_cfg.svh
/*
 Fixed widths, channel numbering and step constants of the peripheral DMA arbiter.
 Assumes it is included by bare name from the package and the design files.
*/
`ifndef PDA_CFG_SVH
`define PDA_CFG_SVH

// Channel counts: receive channels take indices 0..5, transmit 6..10
`define PDA_NCH        11
`define PDA_NRX        6
`define PDA_IW         4

// Receive channel indices, highest priority first; FIRST and SECOND are the usarts
`define PDA_RX_DBG     0
`define PDA_RX_FIRST   1
`define PDA_RX_SECOND  2
`define PDA_RX_SYNC    3
`define PDA_RX_ADC     4
`define PDA_RX_SPI     5
// Transmit channel indices, highest priority first
`define PDA_TX_DBG     6
`define PDA_TX_FIRST   7
`define PDA_TX_SECOND  8
`define PDA_TX_SYNC    9
`define PDA_TX_SPI     10

// Data path widths
`define PDA_AW         32
`define PDA_DW         32
`define PDA_CW         16

// Per-transfer constants and reset values
`define PDA_ADDR_STEP  32'h0000_0004
`define PDA_ADDR_RST   32'h0000_0000
`define PDA_DATA_RST   32'h0000_0000
`define PDA_CNT_ZERO   16'h0000
`define PDA_CNT_ONE    16'h0001

// Two-entry transmit buffer
`define PDA_FIFO_DEPTH 2
`define PDA_FIFO_CW    2
`define PDA_FIFO_FULL  2'h2
`define PDA_FIFO_EMPTY 2'h0
`define PDA_FIFO_ONE   2'h1

`endif

// ### verilog/pda_pkg.sv
/*
 Types shared by the peripheral DMA arbiter and its transmit buffer.
 Assumes pda_cfg.svh is on the include path.
*/
`include "pda_cfg.svh"

package pda_pkg;
    // Transfer sequencer states, one-hot
    typedef enum logic [3:0] {
        ST_IDLE  = 4'h1,
        ST_REQ   = 4'h2,
        ST_XFER1 = 4'h4,
        ST_XFER2 = 4'h8
    } pda_state_t;

    typedef logic [`PDA_IW-1:0] pda_chan_t;
    typedef logic [`PDA_DW-1:0] pda_data_t;
endpackage

// ### verilog/pda_stream_if.sv
/*
 Valid/ready word stream between the arbiter and its transmit buffer.
 Assumes both ends run on the same clock; no clocking block.
*/
`timescale 1ns/1ns
`default_nettype none
`include "pda_cfg.svh"

interface pda_stream_if;
    logic              valid;
    logic              ready;
    pda_pkg::pda_data_t data;
    pda_pkg::pda_chan_t chan;

    modport src (output valid, output data, output chan, input ready);
    modport snk (input valid, input data, input chan, output ready);
endinterface

`default_nettype wire

// ### verilog/pda_fifo2.sv
/*
 Two-entry flip-flop buffer carrying memory-read words toward the peripherals.
 Assumes one clock, asynchronous active-high reset and a common clock enable.
*/
`timescale 1ns/1ns
`default_nettype none
`include "pda_cfg.svh"

module pda_fifo2 (
    input  wire logic     core_clk,
    input  wire logic     rst,
    input  wire logic     ce,
    pda_stream_if.snk     inPort,
    pda_stream_if.src     outPort
);
    pda_pkg::pda_data_t          mem_r   [`PDA_FIFO_DEPTH];
    pda_pkg::pda_data_t          mem_nxt [`PDA_FIFO_DEPTH];
    pda_pkg::pda_chan_t          tag_r   [`PDA_FIFO_DEPTH];
    pda_pkg::pda_chan_t          tag_nxt [`PDA_FIFO_DEPTH];
    logic                        wrPtr_r, wrPtr_nxt;
    logic                        rdPtr_r, rdPtr_nxt;
    logic [`PDA_FIFO_CW-1:0]     cnt_r, cnt_nxt;
    logic                        push, pop;

    // Honest full and empty straight from the fill count
    assign inPort.ready  = (cnt_r != `PDA_FIFO_FULL);
    assign outPort.valid = (cnt_r != `PDA_FIFO_EMPTY);
    assign outPort.data  = mem_r[rdPtr_r];
    assign outPort.chan  = tag_r[rdPtr_r];
    assign push = ce & inPort.valid & inPort.ready;
    assign pop  = ce & outPort.valid & outPort.ready;

    // Next pointers, count and storage
    always_comb begin
        wrPtr_nxt = wrPtr_r;
        rdPtr_nxt = rdPtr_r;
        cnt_nxt   = cnt_r;
        for (int k = 0; k < `PDA_FIFO_DEPTH; k++) begin
            mem_nxt[k] = mem_r[k];
            tag_nxt[k] = tag_r[k];
        end
        if (push) begin
            mem_nxt[wrPtr_r] = inPort.data;
            tag_nxt[wrPtr_r] = inPort.chan;
            wrPtr_nxt = ~wrPtr_r;
        end
        if (pop) begin
            rdPtr_nxt = ~rdPtr_r;
        end
        // Push and pop together leave the count alone
        if (push && !pop) begin
            cnt_nxt = cnt_r + `PDA_FIFO_ONE;
        end else if (pop && !push) begin
            cnt_nxt = cnt_r - `PDA_FIFO_ONE;
        end
    end

    // Registers only; clock enable freezes everything
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wrPtr_r <= 1'b0;
            rdPtr_r <= 1'b0;
            cnt_r   <= `PDA_FIFO_EMPTY;
            for (int k = 0; k < `PDA_FIFO_DEPTH; k++) begin
                mem_r[k] <= `PDA_DATA_RST;
                tag_r[k] <= '0;
            end
        end else if (ce) begin
            wrPtr_r <= wrPtr_nxt;
            rdPtr_r <= rdPtr_nxt;
            cnt_r   <= cnt_nxt;
            for (int k = 0; k < `PDA_FIFO_DEPTH; k++) begin
                mem_r[k] <= mem_nxt[k];
                tag_r[k] <= tag_nxt[k];
            end
        end
    end
endmodule

`default_nettype wire

// ### verilog/pda_arbiter.sv
/*
 Peripheral DMA arbiter: fixed-priority channel selection, bus request toward
 the memory controller, per-channel current and queued buffer descriptors.
 Assumes peripherals and the system bus arbiter run on core_clk, and that the
 bus arbiter keeps its grant while busReq stays high.
*/
`timescale 1ns/1ns
`default_nettype none
`include "pda_cfg.svh"

// Notes on behaviour
// - Eleven channels: rx and tx per serial block and SPI, rx only for ADC.
// - All rx above all tx; debug, first usart, second usart, sync serial, ADC, SPI.
// - Memory-to-peripheral transfer holds the bus one cycle after grant.
// - Peripheral-to-memory transfer holds the bus two cycles after grant.
// - Queued next buffer replaces the finished one without a gap.
// - Bus arbiter grants core or DMA one at a time; we wait for grant.
module pda_arbiter (
    input  wire logic                     core_clk,
    input  wire logic                     rst,
    input  wire logic                     ce,
    input  wire logic [`PDA_NCH-1:0]      chReq,
    output logic      [`PDA_NCH-1:0]      chAck,
    output logic      [`PDA_IW-1:0]       perSel,
    input  wire logic [`PDA_DW-1:0]       perRdData,
    output logic                          busReq,
    input  wire logic                     busGrant,
    output logic      [`PDA_AW-1:0]       memAddr,
    output logic                          memRead,
    output logic                          memWrite,
    output logic      [`PDA_DW-1:0]       memWData,
    input  wire logic [`PDA_DW-1:0]       memRData,
    output logic                          txValid,
    input  wire logic                     txReady,
    output logic      [`PDA_DW-1:0]       txData,
    output logic      [`PDA_IW-1:0]       txChan,
    input  wire logic                     descLoad,
    input  wire logic [`PDA_IW-1:0]       descChan,
    input  wire logic [`PDA_AW-1:0]       descAddr,
    input  wire logic [`PDA_CW-1:0]       descCount,
    output logic      [`PDA_NCH-1:0]      chIdle,
    output logic      [`PDA_NCH-1:0]      chNextFree,
    output logic      [`PDA_NCH-1:0]      chEnd
);
    pda_pkg::pda_state_t state_r, state_nxt;
    pda_pkg::pda_chan_t  winner_r, winner_nxt;
    logic [`PDA_AW-1:0]  xferAddr_r, xferAddr_nxt;
    logic [`PDA_DW-1:0]  rxData_r, rxData_nxt;
    logic [`PDA_AW-1:0]  curAddrV [`PDA_NCH];
    logic [`PDA_NCH-1:0] elig;
    logic                anyElig;
    pda_pkg::pda_chan_t  win;
    logic                isTx;
    logic                doneStb;

    pda_stream_if fifoIn ();
    pda_stream_if fifoOut ();

    // Transmit words pass a two-entry buffer so a stalled receiver loses none
    pda_fifo2 i_pda_fifo2 (
        .core_clk (core_clk),
        .rst      (rst),
        .ce       (ce),
        .inPort   (fifoIn),
        .outPort  (fifoOut)
    );

    assign txValid       = fifoOut.valid;
    assign txData        = fifoOut.data;
    assign txChan        = fifoOut.chan;
    assign fifoOut.ready = txReady;

    // Winner class; tx indices sit above all rx indices
    assign isTx = (winner_r >= pda_pkg::pda_chan_t'(`PDA_NRX));

    // Last bus cycle of the transfer in progress
    assign doneStb = ce & (((state_r == pda_pkg::ST_XFER1) & isTx) |
                           (state_r == pda_pkg::ST_XFER2));

    // Bus request held from request through the last transfer cycle
    assign busReq   = (state_r != pda_pkg::ST_IDLE);
    assign memAddr  = xferAddr_r;
    assign memRead  = ce & (state_r == pda_pkg::ST_XFER1) & isTx;
    assign memWrite = ce & (state_r == pda_pkg::ST_XFER2);
    assign memWData = rxData_r;
    assign perSel   = winner_r;

    // Memory word goes to the buffer in the same single bus cycle
    assign fifoIn.valid = memRead;
    assign fifoIn.data  = memRData;
    assign fifoIn.chan  = winner_r;

    // Per-channel descriptors: current buffer plus one queued buffer
    for (genvar i = 0; i < `PDA_NCH; i++) begin : g_ch
        logic [`PDA_AW-1:0] curAddr_r, curAddr_nxt;
        logic [`PDA_CW-1:0] curCnt_r, curCnt_nxt;
        logic [`PDA_AW-1:0] nxtAddr_r, nxtAddr_nxt;
        logic [`PDA_CW-1:0] nxtCnt_r, nxtCnt_nxt;
        logic               end_r, end_nxt;
        logic               hit;
        logic               roomOk;

        assign hit = doneStb & (winner_r == pda_pkg::pda_chan_t'(i));
        assign chAck[i] = hit;
        // Tx channels wait while the buffer has no room, so it never overflows
        if (i >= `PDA_NRX) begin : g_tx
            assign roomOk = fifoIn.ready;
        end else begin : g_rx
            assign roomOk = 1'b1;
        end
        assign elig[i]       = chReq[i] & (curCnt_r != `PDA_CNT_ZERO) & roomOk;
        assign curAddrV[i]   = curAddr_r;
        assign chIdle[i]     = (curCnt_r == `PDA_CNT_ZERO);
        assign chNextFree[i] = (nxtCnt_r == `PDA_CNT_ZERO);
        assign chEnd[i]      = end_r;

        // Advance, promote the queued buffer, then apply a software load
        always_comb begin
            curAddr_nxt = curAddr_r;
            curCnt_nxt  = curCnt_r;
            nxtAddr_nxt = nxtAddr_r;
            nxtCnt_nxt  = nxtCnt_r;
            end_nxt     = 1'b0;
            if (hit) begin
                curAddr_nxt = curAddr_r + `PDA_ADDR_STEP;
                curCnt_nxt  = curCnt_r - `PDA_CNT_ONE;
                if (curCnt_r == `PDA_CNT_ONE) begin
                    end_nxt = 1'b1;
                    if (nxtCnt_r != `PDA_CNT_ZERO) begin
                        curAddr_nxt = nxtAddr_r;
                        curCnt_nxt  = nxtCnt_r;
                        nxtCnt_nxt  = `PDA_CNT_ZERO;
                    end
                end
            end
            // A load meeting a finishing buffer lands where it is needed
            if (descLoad && (descChan == pda_pkg::pda_chan_t'(i))) begin
                if (curCnt_nxt == `PDA_CNT_ZERO) begin
                    curAddr_nxt = descAddr;
                    curCnt_nxt  = descCount;
                end else begin
                    nxtAddr_nxt = descAddr;
                    nxtCnt_nxt  = descCount;
                end
            end
        end

        always_ff @(posedge core_clk or posedge rst) begin
            if (rst) begin
                curAddr_r <= `PDA_ADDR_RST;
                curCnt_r  <= `PDA_CNT_ZERO;
                nxtAddr_r <= `PDA_ADDR_RST;
                nxtCnt_r  <= `PDA_CNT_ZERO;
                end_r     <= 1'b0;
            end else if (ce) begin
                curAddr_r <= curAddr_nxt;
                curCnt_r  <= curCnt_nxt;
                nxtAddr_r <= nxtAddr_nxt;
                nxtCnt_r  <= nxtCnt_nxt;
                end_r     <= end_nxt;
            end
        end
    end

    // Fixed priority: lowest index wins, scanning from the top index down
    always_comb begin
        win     = '0;
        anyElig = |elig;
        for (int j = `PDA_NCH - 1; j >= 0; j--) begin
            if (elig[j]) begin
                win = pda_pkg::pda_chan_t'(j);
            end
        end
    end

    // Sequencer: pick, request bus, transfer, always back to idle
    always_comb begin
        state_nxt    = state_r;
        winner_nxt   = winner_r;
        xferAddr_nxt = xferAddr_r;
        rxData_nxt   = rxData_r;
        case (state_r)
            pda_pkg::ST_IDLE: begin
                if (anyElig) begin
                    winner_nxt   = win;
                    xferAddr_nxt = curAddrV[win];
                    state_nxt    = pda_pkg::ST_REQ;
                end
            end
            pda_pkg::ST_REQ: begin
                if (busGrant) begin
                    state_nxt = pda_pkg::ST_XFER1;
                end
            end
            pda_pkg::ST_XFER1: begin
                if (isTx) begin
                    state_nxt = pda_pkg::ST_IDLE;
                end else begin
                    rxData_nxt = perRdData;
                    state_nxt  = pda_pkg::ST_XFER2;
                end
            end
            pda_pkg::ST_XFER2: begin
                state_nxt = pda_pkg::ST_IDLE;
            end
            default: begin
                state_nxt = pda_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_r    <= pda_pkg::ST_IDLE;
            winner_r   <= '0;
            xferAddr_r <= `PDA_ADDR_RST;
            rxData_r   <= `PDA_DATA_RST;
        end else if (ce) begin
            state_r    <= state_nxt;
            winner_r   <= winner_nxt;
            xferAddr_r <= xferAddr_nxt;
            rxData_r   <= rxData_nxt;
        end
    end
endmodule

`default_nettype wire

// ### tb/pda_bus_model.sv
/*
 Far side of the arbiter: system bus arbiter grant and memory read data.
 Assumes the same core_clk and rst as the arbiter; slow selects a late grant.
*/
`timescale 1ns/1ns
`default_nettype none

module pda_bus_model (
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        slow,
    input  wire logic        busReq,
    input  wire logic        memRead,
    input  wire logic [31:0] memAddr,
    output logic             busGrant,
    output logic [31:0]      memRData
);
    logic [1:0] waitCnt_r;

    // Cycles of request seen; cleared whenever the request drops
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst)
            waitCnt_r <= 2'h0;
        else if (!busReq)
            waitCnt_r <= 2'h0;
        else if (waitCnt_r != 2'h3)
            waitCnt_r <= waitCnt_r + 2'h1;
    end

    // Grant held while the request stays up; the core owns the bus otherwise
    assign busGrant = busReq && (!slow || waitCnt_r == 2'h3);
    // Data valid only in the read cycle, inverted elsewhere so stale use shows
    assign memRData = memRead ? (memAddr ^ 32'h5a5a_5a5a) : ~(memAddr ^ 32'h5a5a_5a5a);
endmodule

`default_nettype wire

// ### tb/pda_arbiter_props.sv
/*
 Concurrent checks on the arbiter's ports, attached by bind.
 Assumes a single clock domain and the grant held while busReq is high.
*/
`timescale 1ns/1ns
`default_nettype none
`include "pda_cfg.svh"

module pda_arbiter_chk (
    input  wire logic                core_clk,
    input  wire logic                rst,
    input  wire logic [`PDA_NCH-1:0] chReq,
    input  wire logic [`PDA_NCH-1:0] chAck,
    input  wire logic [`PDA_IW-1:0]  perSel,
    input  wire logic                busReq,
    input  wire logic                busGrant,
    input  wire logic                memRead,
    input  wire logic                memWrite,
    input  wire logic [`PDA_NCH-1:0] chIdle,
    input  wire logic [`PDA_NCH-1:0] chEnd
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    // Transfer timing against the grant
    a_tx_one_cycle: assert property (memRead |-> $past(busReq && busGrant)
        && !$past(busReq && busGrant, 2)) else $error("read not one cycle after grant");
    a_rx_two_cycles: assert property (memWrite |-> $past(busReq && busGrant, 2)
        && !$past(busReq && busGrant, 3)) else $error("write not two cycles after grant");
    a_owner_granted: assert property ((memRead || memWrite) |-> busGrant)
        else $error("transfer without grant");
    a_wait_grant: assert property (busReq && !busGrant |=> !memRead && !memWrite)
        else $error("transfer before grant");
    // One transfer for one channel, then re-evaluation
    a_release_after: assert property ((memRead || memWrite) |=> !busReq)
        else $error("bus kept after transfer");
    a_ack_onehot: assert property (|chAck |-> $onehot(chAck) && (memRead || memWrite))
        else $error("bad acknowledge");
    a_ack_selected: assert property (|chAck |-> chAck == (11'h1 << perSel))
        else $error("acknowledge not for selected channel");
    a_top_pending: assert property ($rose(busReq) |->
        ($past(chReq & ~chIdle) & ((11'h1 << perSel) - 11'h1)) == 11'h0)
        else $error("higher ranked channel passed over");
    a_end_after_ack: assert property (|chEnd |-> (chEnd & ~$past(chAck)) == 11'h0)
        else $error("buffer end without acknowledge");

    cover property (memRead);
    cover property (memWrite);
    cover property (busReq && !busGrant);
    cover property (|chEnd);
endmodule

bind pda_arbiter pda_arbiter_chk i_pda_arbiter_chk (.core_clk(core_clk), .rst(rst),
    .chReq(chReq), .chAck(chAck), .perSel(perSel), .busReq(busReq), .busGrant(busGrant),
    .memRead(memRead), .memWrite(memWrite), .chIdle(chIdle), .chEnd(chEnd));

`default_nettype wire

// ### tb/test_peripheral_dma_priority_arbiter.sv
/*
 Self-checking bench for the arbiter: per-channel transfers, ranking, buffer stall, queue.
 Assumes the bus model answers reads and grants; inputs change on falling edges.
*/
`timescale 1ns/1ns
`default_nettype none
`include "pda_cfg.svh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin miscompares++; \
    $display("ERROR %0t: got %h expected %h", $time, g, e); end end

module test_peripheral_dma_priority_arbiter;
    logic        core_clk = 1'b0, rst = 1'b1, ce = 1'b1, slow = 1'b0;
    logic        descLoad = 1'b0, txReady = 1'b1, busReq, busGrant, memRead, memWrite, txValid;
    logic [10:0] chReq = 11'h0, chAck, chIdle, chNextFree, chEnd;
    logic [3:0]  descChan = 4'h0, perSel, txChan;
    logic [31:0] descAddr = 32'h0, perRdData, memAddr, memWData, memRData, txData;
    logic [15:0] descCount = 16'h0;
    int          miscompares = 0, checks_done = 0;

    // Peripheral data tagged by channel so a wrong selection shows
    assign perRdData = 32'ha5a5_0000 | {28'h0, perSel};
    always #50 core_clk = ~core_clk;

    pda_arbiter i_pda_arbiter (.core_clk(core_clk), .rst(rst), .ce(ce), .chReq(chReq),
        .chAck(chAck), .perSel(perSel), .perRdData(perRdData), .busReq(busReq),
        .busGrant(busGrant), .memAddr(memAddr), .memRead(memRead), .memWrite(memWrite),
        .memWData(memWData), .memRData(memRData), .txValid(txValid), .txReady(txReady),
        .txData(txData), .txChan(txChan), .descLoad(descLoad), .descChan(descChan),
        .descAddr(descAddr), .descCount(descCount), .chIdle(chIdle),
        .chNextFree(chNextFree), .chEnd(chEnd));
    pda_bus_model i_pda_bus_model (.core_clk(core_clk), .rst(rst), .slow(slow),
        .busReq(busReq), .memRead(memRead), .memAddr(memAddr), .busGrant(busGrant),
        .memRData(memRData));

    task automatic wrap_up;
        if (miscompares == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic load(input logic [3:0] ch, input logic [31:0] a, input logic [15:0] n);
        @(negedge core_clk);
        descLoad = 1'b1; descChan = ch; descAddr = a; descCount = n;
        @(negedge core_clk);
        descLoad = 1'b0;
    endtask

    // Bounded wait for an acknowledge; n counts bus-held cycles before it
    task automatic wait_ack(output logic [10:0] a, output int n);
        int i;
        n = 0;
        @(negedge core_clk);
        for (i = 0; i < 60 && !(|chAck); i++) begin
            n += (busReq === 1'b1);
            @(negedge core_clk);
        end
        if (i == 60) begin
            miscompares++;
            wrap_up();
        end else
            a = chAck;
    endtask

    // Each channel alone, fast grant
    task automatic sc_each;
        logic [10:0] a;
        int n;
        for (int c = 0; c < 11; c++) begin
            load(c[3:0], 32'h100 * c, 16'h1);
            chReq[c] = 1'b1;
            wait_ack(a, n);
            `CHK(a, 11'h1 << c)
            `CHK(memAddr, 32'h100 * c)
            `CHK(n, (c < 6) ? 2 : 1)
            if (c < 6) begin
                `CHK(memWrite, 1'b1)
                `CHK(memWData, 32'ha5a5_0000 | c)
            end else
                `CHK(memRead, 1'b1)
            @(negedge core_clk);
            chReq[c] = 1'b0;
            `CHK(chEnd, 11'h1 << c)
            `CHK(busReq, 1'b0)
        end
    endtask

    // All channels at once, slow grant, receiver stalled until the buffer fills
    task automatic sc_prio;
        logic [10:0] a;
        int n;
        for (int c = 0; c < 11; c++)
            load(c[3:0], 32'h100 * c, 16'h1);
        txReady = 1'b0; slow = 1'b1; chReq = 11'h7ff;
        for (int c = 0; c < 11; c++) begin
            if (c == 8) begin
                // Two words held; remaining transmit channels must wait
                repeat (10) begin
                    @(negedge core_clk);
                    `CHK(busReq, 1'b0)
                end
                `CHK(txValid, 1'b1)
                `CHK(txChan, 4'h6)
                `CHK(txData, 32'h600 ^ 32'h5a5a_5a5a)
                txReady = 1'b1;
            end
            wait_ack(a, n);
            `CHK(a, 11'h1 << c)
            chReq[c] = 1'b0;
        end
        slow = 1'b0;
        repeat (4) @(negedge core_clk);
        `CHK(txValid, 1'b0)
    endtask

    // Queued descriptor follows the current one without a gap
    task automatic sc_queue;
        logic [10:0] a;
        int n;
        load(4'h0, 32'h1000, 16'h2);
        load(4'h0, 32'h2000, 16'h1);
        `CHK(chNextFree[0], 1'b0)
        chReq[0] = 1'b1;
        for (int k = 0; k < 3; k++) begin
            wait_ack(a, n);
            `CHK(memAddr, (k == 2) ? 32'h2000 : 32'h1000 + 4 * k)
        end
        chReq[0] = 1'b0;
        repeat (2) @(negedge core_clk);
        `CHK(chIdle[0], 1'b1)
        `CHK(chNextFree[0], 1'b1)
    endtask

    // Enable low freezes selection and loads; a mid-run reset clears every channel
    task automatic sc_hold;
        logic [10:0] a;
        int n;
        load(4'h1, 32'h3000, 16'h2);
        ce = 1'b0;
        load(4'h1, 32'h4000, 16'h1);
        chReq[1] = 1'b1;
        repeat (3) @(negedge core_clk);
        `CHK(busReq, 1'b0)
        `CHK(chIdle[1], 1'b0)
        `CHK(chNextFree[1], 1'b1)
        ce = 1'b1;
        wait_ack(a, n);
        `CHK(a, 11'h002)
        `CHK(memAddr, 32'h3000)
        @(negedge core_clk);
        rst = 1'b1;
        @(negedge core_clk);
        `CHK(chIdle, 11'h7ff)
        `CHK(chNextFree, 11'h7ff)
        `CHK(busReq, 1'b0)
        chReq[1] = 1'b0;
        rst = 1'b0;
        // Stalled receiver keeps the word visible for the check
        txReady = 1'b0;
        load(4'h6, 32'h700, 16'h1);
        chReq[6] = 1'b1;
        wait_ack(a, n);
        `CHK(a, 11'h040)
        `CHK(memAddr, 32'h700)
        chReq[6] = 1'b0;
        @(negedge core_clk);
        `CHK(txValid, 1'b1)
        `CHK(txChan, 4'h6)
        `CHK(txData, 32'h700 ^ 32'h5a5a_5a5a)
        txReady = 1'b1;
        @(negedge core_clk);
        `CHK(txValid, 1'b0)
    endtask

    initial begin
        repeat (16) @(posedge core_clk);
        @(negedge core_clk);
        rst = 1'b0;
        sc_each();
        sc_prio();
        sc_queue();
        sc_hold();
        wrap_up();
    end
endmodule

`default_nettype wire
